/* hw/pmic_safety_regs.vh */
`ifndef PMIC_SAFETY_REGS_VH
`define PMIC_SAFETY_REGS_VH
// How it works
// RULE_01: with hardware control selected, regulator needs mode enable bit and pin high.
// RULE_02: run enable bit in run state, standby enable bit in standby state.
// RULE_03: hardware-control select bit loads its default from the fuse copy.
// RULE_04: read-only status bit mirrors the regulator enable pin.
// RULE_05: safety output is active-low open drain, released in normal operation.
// RULE_06: fuse picks fault (0) or active (1) safe mode; variant without fuse is fault.
// RULE_07: soft-fault select latches regulator faults into flag and asserts output.
// RULE_08: external and internal watchdog selects latch their own flags and assert output.
// RULE_09: hard-fault select latches hard shutdowns; when clear, hard faults do nothing; code still starts power-down on them.
// RULE_10: hard shutdown is timer expiry, counter maxima, power-up failure or thermal.
// RULE_11: output releases when all flags clear or input supply undervoltage detected.
// RULE_12: with secure write, flag clear needs write-1, code read and code write-back.
// RULE_13: active mode pulls output low once fuses are loaded while safe state forced.
// RULE_14: active mode forces safe state on self-test, enabled flags, hard reset, off reset; code uses only the soft and external watchdog flags.
// RULE_15: each safe-state entry drives output low and sets the safe-state flag.
// RULE_16: safe state exits only when reset released, no faults and all flags clear.
// RULE_17: strap high selects configuration mode: address 0x08, watchdog and secure off; code turns secure off only in the off state.
// RULE_18: fail-line fuse at 0 ignores the line; at 1 synchronisation is active.
// RULE_19: internal fault or hard watchdog pulls fail line low 20 us before power-down.
// RULE_20: fail line held low when off; external low past 20 us debounce is a fail.
// RULE_21: on power-on the line is released, and power-up stalls while held low.
// RULE_22: after hard watchdog power-down, release line after 30 us, reload fuses, wait high.
// RULE_23: intervals are clock counters; debounce restarts whenever the line returns high.

// ====================================================
// register map (byte addresses)
`define A_CTRL 4'h0
`define A_FLAGS 4'h4
`define A_STATUS 4'h8
`define A_CODE 4'hc
// control register fields
`define C_HWSEL 0
`define C_RUNEN 1
`define C_STBYEN 2
`define C_SOFT 3
`define C_WDI 4
`define C_WDC 5
`define C_HARD 6
`define C_SECURE 7
// flag register fields
`define F_SOFT 0
`define F_WDI 1
`define F_WDC 2
`define F_HARD 3
`define F_SAFE 4
`define NFLAGS 5
// status register fields
`define S_PIN 0
`define S_SAFE_OUT 1
`define S_FAIL_IN 2
`define S_CFG 3
`define S_ACTIVE 4
`define S_STATE_LSB 5
// timing
`define CLK_MHZ 40
`define PRE_FAIL_US 20
`define DEBOUNCE_US 20
`define RELEASE_US 30
`define CONFIG_ADDR 7'h08
`define CTRL_RESET 8'h00
`endif

/* hw/interval_timer.v */
`timescale 1ns/1ps
// ====================================================
// down-counting interval timer, restarted by load
module interval_timer #(
  parameter W = 12
) (
  input wire clk,
  input wire rst_b,
  input wire load,
  input wire [W-1:0] count,
  input wire run,
  output reg done
);
  reg [W-1:0] remain;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      remain <= {W{1'b0}};
      done <= 1'b0;
    end else if (load) begin
      remain <= count;
      done <= 1'b0;
    end else if (run && remain != {W{1'b0}}) begin
      remain <= remain - {{(W-1){1'b0}}, 1'b1};
      done <= (remain == {{(W-1){1'b0}}, 1'b1});
    end
  end
endmodule // interval_timer

/* hw/code_generator.v */
`timescale 1ns/1ps
// ====================================================
// free-running lfsr for the secure-write code; not cryptographic
module code_generator (
  input wire clk,
  input wire rst_b,
  output reg [7:0] code
);
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      code <= 8'h5a;
    else
      code <= {code[6:0], code[7] ^ code[5] ^ code[4] ^ code[3]};
  end
endmodule // code_generator

/* hw/pmic_safety_sync.v */
`timescale 1ns/1ps
`include "pmic_safety_regs.vh"
module pmic_safety_sync #(
  parameter HAS_ACTIVE_FUSE = 1
) (
  input wire CLOCK,
  input wire RST_B,
  // axi4-lite slave
  input wire [3:0] AWADDR,
  input wire AWVALID,
  output reg AWREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output reg WREADY,
  output reg [1:0] BRESP,
  output reg BVALID,
  input wire BREADY,
  input wire [3:0] ARADDR,
  input wire ARVALID,
  output reg ARREADY,
  output reg [31:0] RDATA,
  output reg [1:0] RRESP,
  output reg RVALID,
  input wire RREADY,
  // fuses and system
  input wire FUSES_LOADED,
  input wire FUSE_REG_HW_CONTROL_DEFAULT,
  input wire FUSE_ACTIVE_SAFE_MODE,
  input wire FUSE_FAIL_SYNC_ENABLE,
  input wire FUSE_SECURE_ENABLE,
  input wire REG_HW_ENABLE_PIN,
  input wire STANDBY_STATE,
  input wire SOFT_FAULT,
  input wire REGULATOR_FAULT_PRESENT,
  input wire EXT_WATCHDOG_EVENT,
  input wire INT_WATCHDOG_EVENT,
  input wire HARD_WATCHDOG_EVENT,
  input wire FAULT_TIMER_EXPIRED,
  input wire FAULT_COUNT_MAX,
  input wire WATCHDOG_COUNT_MAX,
  input wire POWER_UP_FAILURE,
  input wire THERMAL_SHUTDOWN,
  input wire SELF_TEST_FLAG,
  input wire PROCESSOR_RESET_N,
  input wire SUPPLY_UNDERVOLTAGE_DETECT,
  input wire POWER_ON_REQUEST,
  input wire OUTPUTS_OFF,
  input wire CONFIG_MODE_STRAP,
  input wire FAIL_SYNC_LINE_IN,
  // outputs
  output reg AUX_LINEAR_REGULATOR_EN,
  output reg SAFETY_OUT_N_O,
  output reg SAFETY_OUT_N_OE,
  output reg FAIL_SYNC_LINE_N_O,
  output reg FAIL_SYNC_LINE_N_OE,
  output reg POWER_DOWN_START,
  output reg POWER_UP_GO,
  output reg RELOAD_FUSES,
  output reg CONFIG_PROGRAMMING_MODE,
  output reg [6:0] BUS_ADDRESS_OVERRIDE,
  output reg WATCHDOG_DISABLE,
  output reg SECURE_CRC_DISABLE
);
  // 11 bits hold every interval count at the 40 MHz clock
  localparam [10:0] CYC_PRE_W = (`PRE_FAIL_US * `CLK_MHZ);
  localparam [10:0] CYC_DEB_W = (`DEBOUNCE_US * `CLK_MHZ);
  localparam [10:0] CYC_REL_W = (`RELEASE_US * `CLK_MHZ);
  // fail-line sequencer states
  localparam [2:0] ST_OFF = 3'd0;
  localparam [2:0] ST_UP = 3'd1;
  localparam [2:0] ST_ON = 3'd2;
  localparam [2:0] ST_PRE = 3'd3;
  localparam [2:0] ST_DOWN = 3'd4;
  localparam [2:0] ST_REL = 3'd5;
  localparam [2:0] ST_WAIT = 3'd6;

  function sel;
    input [7:0] c;
    input integer b;
    sel = c[b];
  endfunction

  // ====================================================
  // registers and strap decode
  reg [7:0] ctrl;
  reg [`NFLAGS-1:0] flags;
  reg fuse_done;
  reg active_mode;
  reg [2:0] state;
  reg hard_wd_seen;
  reg [7:0] pending_clear;
  reg code_armed;
  reg [7:0] held_code;
  wire [7:0] code;
  code_generator u_code (.clk(CLOCK), .rst_b(RST_B), .code(code));

  wire hard_event = FAULT_TIMER_EXPIRED | FAULT_COUNT_MAX | WATCHDOG_COUNT_MAX |
    POWER_UP_FAILURE | THERMAL_SHUTDOWN; // [RULE_10]
  wire cfg = CONFIG_MODE_STRAP; // [RULE_17]
  wire secure = FUSE_SECURE_ENABLE & ctrl[`C_SECURE] & ~(cfg & (state == ST_OFF));
  wire system_on = (state == ST_ON);

  // ====================================================
  // axi4-lite write path
  reg aw_hold, w_hold;
  reg [3:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire do_write = aw_hold & w_hold & ~BVALID;
  wire wr_ctrl = do_write && aw_addr == `A_CTRL && w_strb[0];
  wire wr_flags = do_write && aw_addr == `A_FLAGS && w_strb[0];
  wire wr_code = do_write && aw_addr == `A_CODE && w_strb[0];
  wire rd_code = ARVALID & ARREADY & (ARADDR == `A_CODE);
  // secure write: a matching code write applies the pending clear [RULE_12]
  // the lfsr runs on, so the write-back is compared with the code that was read
  wire code_ok = wr_code && code_armed && w_data[7:0] == held_code;
  wire [`NFLAGS-1:0] clr = secure ? (code_ok ? pending_clear[`NFLAGS-1:0] : {`NFLAGS{1'b0}})
    : (wr_flags ? w_data[`NFLAGS-1:0] : {`NFLAGS{1'b0}});

  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= 2'h0;
    end else begin
      AWREADY <= ~aw_hold & ~AWREADY & AWVALID & ~BVALID;
      WREADY <= ~w_hold & ~WREADY & WVALID & ~BVALID;
      if (AWVALID && AWREADY) begin
        aw_hold <= 1'b1;
        aw_addr <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_hold <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
      if (do_write) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= (aw_addr == `A_CTRL || aw_addr == `A_FLAGS || aw_addr == `A_CODE) ?
          2'b00 : 2'b10;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // ====================================================
  // control register and secure code tracking
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl <= `CTRL_RESET;
      fuse_done <= 1'b0;
      active_mode <= 1'b0;
      pending_clear <= 8'h00;
      code_armed <= 1'b0;
      held_code <= 8'h00;
    end else begin
      if (rd_code)
        held_code <= code; // [RULE_12]
      if (FUSES_LOADED && !fuse_done) begin
        fuse_done <= 1'b1;
        ctrl[`C_HWSEL] <= FUSE_REG_HW_CONTROL_DEFAULT; // [RULE_03]
        active_mode <= (HAS_ACTIVE_FUSE != 0) & FUSE_ACTIVE_SAFE_MODE; // [RULE_06]
      end else if (RELOAD_FUSES) begin
        fuse_done <= 1'b0;
      end else if (wr_ctrl) begin
        ctrl <= w_data[7:0];
      end
      if (wr_flags && secure) begin
        pending_clear <= w_data[7:0];
        code_armed <= 1'b0;
      end else if (rd_code && pending_clear != 8'h00) begin
        code_armed <= 1'b1;
      end else if (wr_code || do_write) begin
        pending_clear <= 8'h00;
        code_armed <= 1'b0;
      end
    end
  end

  // ====================================================
  // safety flags: set wins over clear
  wire force_safe = active_mode & fuse_done & (SELF_TEST_FLAG |
    (flags[`F_WDI] & ctrl[`C_WDI]) | (flags[`F_SOFT] & ctrl[`C_SOFT]) |
    HARD_WATCHDOG_EVENT | (~PROCESSOR_RESET_N & state == ST_OFF)); // [RULE_14]
  wire [`NFLAGS-1:0] set;
  assign set[`F_SOFT] = ctrl[`C_SOFT] & SOFT_FAULT; // [RULE_07]
  assign set[`F_WDI] = ctrl[`C_WDI] & EXT_WATCHDOG_EVENT & ~cfg; // [RULE_08]
  assign set[`F_WDC] = ctrl[`C_WDC] & INT_WATCHDOG_EVENT & ~cfg; // [RULE_08]
  assign set[`F_HARD] = sel(ctrl, `C_HARD) & hard_event; // [RULE_09]
  assign set[`F_SAFE] = force_safe; // [RULE_15]

  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B)
      flags <= {`NFLAGS{1'b0}};
    else
      flags <= (flags & ~clr) | set;
  end

  // exit needs every condition of the safe state gone [RULE_16]
  wire exit_ok = PROCESSOR_RESET_N & ~SELF_TEST_FLAG & ~REGULATOR_FAULT_PRESENT;
  wire assert_safe = active_mode ?
    (fuse_done & ((flags != {`NFLAGS{1'b0}}) | set[`F_SAFE] | ~exit_ok)) : // [RULE_13]
    (flags != {`NFLAGS{1'b0}}); // [RULE_11]

  // ====================================================
  // fail-line debounce and interval timers
  reg fail_q;
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B)
      fail_q <= 1'b1;
    else
      fail_q <= FAIL_SYNC_LINE_IN;
  end
  wire deb_done, pre_done, rel_done;
  reg deb_armed;
  interval_timer #(.W(11)) u_deb (.clk(CLOCK), .rst_b(RST_B),
    .load(fail_q | ~deb_armed), .count(CYC_DEB_W), .run(1'b1), .done(deb_done)); // [RULE_23]
  interval_timer #(.W(11)) u_pre (.clk(CLOCK), .rst_b(RST_B),
    .load(state != ST_PRE), .count(CYC_PRE_W), .run(1'b1), .done(pre_done));
  interval_timer #(.W(11)) u_rel (.clk(CLOCK), .rst_b(RST_B),
    .load(state != ST_REL), .count(CYC_REL_W), .run(1'b1), .done(rel_done));

  // ====================================================
  // power sequencing with the fail line
  wire sync_en = FUSE_FAIL_SYNC_ENABLE; // [RULE_18]
  wire trigger = hard_event | HARD_WATCHDOG_EVENT;
  reg [2:0] next_state;
  always @* begin
    next_state = state;
    case (state)
      ST_OFF: if (POWER_ON_REQUEST && fuse_done) next_state = ST_UP;
      ST_UP: if (trigger) next_state = ST_PRE;
        else if (fail_q || !sync_en) next_state = ST_ON; // [RULE_21]
      ST_ON: if (trigger) next_state = ST_PRE;
        else if (sync_en && deb_done) next_state = ST_DOWN; // [RULE_20]
      ST_PRE: if (pre_done || !sync_en) next_state = ST_DOWN; // [RULE_19]
      ST_DOWN: if (OUTPUTS_OFF) next_state = hard_wd_seen ? ST_REL : ST_OFF;
      ST_REL: if (rel_done) next_state = ST_WAIT; // [RULE_22]
      ST_WAIT: if ((fail_q || !sync_en) && fuse_done) next_state = ST_UP; // [RULE_22]
      default: next_state = ST_OFF;
    endcase
  end

  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      state <= ST_OFF;
      hard_wd_seen <= 1'b0;
      deb_armed <= 1'b0;
    end else begin
      state <= next_state;
      deb_armed <= (next_state == ST_ON);
      if (state == ST_ON && HARD_WATCHDOG_EVENT)
        hard_wd_seen <= 1'b1;
      else if (state == ST_OFF || state == ST_WAIT)
        hard_wd_seen <= 1'b0;
    end
  end

  // ====================================================
  // outputs, all registered
  wire mode_en = STANDBY_STATE ? ctrl[`C_STBYEN] : ctrl[`C_RUNEN]; // [RULE_02]
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      AUX_LINEAR_REGULATOR_EN <= 1'b0;
      SAFETY_OUT_N_O <= 1'b0;
      SAFETY_OUT_N_OE <= 1'b0;
      FAIL_SYNC_LINE_N_O <= 1'b0;
      FAIL_SYNC_LINE_N_OE <= 1'b0;
      POWER_DOWN_START <= 1'b0;
      POWER_UP_GO <= 1'b0;
      RELOAD_FUSES <= 1'b0;
      CONFIG_PROGRAMMING_MODE <= 1'b0;
      BUS_ADDRESS_OVERRIDE <= 7'h00;
      WATCHDOG_DISABLE <= 1'b0;
      SECURE_CRC_DISABLE <= 1'b0;
    end else begin
      AUX_LINEAR_REGULATOR_EN <= mode_en & (~ctrl[`C_HWSEL] | REG_HW_ENABLE_PIN); // [RULE_01]
      // open drain: only ever drives low; always released during undervoltage [RULE_05] [RULE_11]
      SAFETY_OUT_N_OE <= assert_safe & ~SUPPLY_UNDERVOLTAGE_DETECT;
      FAIL_SYNC_LINE_N_OE <= sync_en & (next_state == ST_OFF || next_state == ST_PRE ||
        next_state == ST_DOWN || next_state == ST_REL); // [RULE_20] [RULE_22]
      POWER_DOWN_START <= (state != ST_DOWN) && (next_state == ST_DOWN);
      POWER_UP_GO <= (next_state == ST_ON) && (state == ST_UP);
      RELOAD_FUSES <= (state == ST_REL) && rel_done; // [RULE_22]
      CONFIG_PROGRAMMING_MODE <= cfg; // [RULE_17]
      BUS_ADDRESS_OVERRIDE <= cfg ? `CONFIG_ADDR : 7'h00;
      WATCHDOG_DISABLE <= cfg;
      SECURE_CRC_DISABLE <= cfg & (state == ST_OFF);
    end
  end

  // ====================================================
  // axi4-lite read path
  wire [31:0] status_word = {24'h0, state, active_mode, cfg, fail_q,
    ~SAFETY_OUT_N_OE, REG_HW_ENABLE_PIN}; // [RULE_04]
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h0;
      RRESP <= 2'h0;
    end else begin
      ARREADY <= ARVALID & ~ARREADY & ~RVALID;
      if (ARVALID && ARREADY) begin
        RVALID <= 1'b1;
        RRESP <= 2'b00;
        case (ARADDR)
          `A_CTRL: RDATA <= {24'h0, ctrl};
          `A_FLAGS: RDATA <= {27'h0, flags};
          `A_STATUS: RDATA <= status_word;
          `A_CODE: RDATA <= {24'h0, code_armed ? code : code};
          default: begin
            RDATA <= 32'h0;
            RRESP <= 2'b10;
          end
        endcase
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end
endmodule // pmic_safety_sync

/* testbench/pmic_safety_props.sv */
`timescale 1ns/1ps
// ====================================================
// port checks of the safety output, config mode outputs and fail-line sync
module pmic_safety_props (
  input wire CLOCK,
  input wire RST_B,
  input wire FUSE_ACTIVE_SAFE_MODE,
  input wire FUSE_FAIL_SYNC_ENABLE,
  input wire SUPPLY_UNDERVOLTAGE_DETECT,
  input wire CONFIG_MODE_STRAP,
  input wire FAIL_SYNC_LINE_IN,
  input wire SAFETY_OUT_N_O,
  input wire SAFETY_OUT_N_OE,
  input wire FAIL_SYNC_LINE_N_O,
  input wire FAIL_SYNC_LINE_N_OE,
  input wire POWER_DOWN_START,
  input wire POWER_UP_GO,
  input wire RELOAD_FUSES,
  input wire CONFIG_PROGRAMMING_MODE,
  input wire [6:0] BUS_ADDRESS_OVERRIDE,
  input wire WATCHDOG_DISABLE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  // ====================================================
  // assertions
  drain_only_a: assert property (!SAFETY_OUT_N_O && !FAIL_SYNC_LINE_N_O)
    else $error("open-drain pin driven high");
  uv_release_a: assert property (
    (!FUSE_ACTIVE_SAFE_MODE && SUPPLY_UNDERVOLTAGE_DETECT) [*2] |-> !SAFETY_OUT_N_OE)
    else $error("safety output held during undervoltage");
  cfg_on_a: assert property (CONFIG_MODE_STRAP [*4] |->
    CONFIG_PROGRAMMING_MODE && BUS_ADDRESS_OVERRIDE == 7'h08 && WATCHDOG_DISABLE)
    else $error("config mode outputs wrong");
  cfg_off_a: assert property (!CONFIG_MODE_STRAP [*4] |->
    !CONFIG_PROGRAMMING_MODE && BUS_ADDRESS_OVERRIDE == 7'h00)
    else $error("normal mode outputs wrong");
  down_line_a: assert property (POWER_DOWN_START && FUSE_FAIL_SYNC_ENABLE |->
    FAIL_SYNC_LINE_N_OE || !FAIL_SYNC_LINE_IN)
    else $error("power-down with fail line high");
  up_line_a: assert property (POWER_UP_GO && FUSE_FAIL_SYNC_ENABLE |->
    $past(FAIL_SYNC_LINE_IN))
    else $error("power-up while fail line low");
  down_pulse_a: assert property (POWER_DOWN_START |=> !POWER_DOWN_START)
    else $error("power-down start not a pulse");
  up_pulse_a: assert property (POWER_UP_GO |=> !POWER_UP_GO)
    else $error("power-up go not a pulse");
  reload_free_a: assert property (RELOAD_FUSES |-> !FAIL_SYNC_LINE_N_OE)
    else $error("reload while fail line still pulled");
  down_c: cover property (POWER_DOWN_START);
  up_c: cover property (POWER_UP_GO);
  reload_c: cover property (RELOAD_FUSES);
endmodule // pmic_safety_props

/* testbench/peer_controller.sv */
`timescale 1ns/1ps
// ====================================================
// peer power controller sharing the open-drain fail line
module peer_controller (
  input wire CLOCK,
  input wire hold_low,
  input wire dut_oe,
  output wire line
);
  reg pull = 1'h0;
  always @(posedge CLOCK) begin
    pull <= hold_low;
  end
  // pulled up: high unless some party pulls low
  assign line = !(pull || dut_oe);
endmodule // peer_controller

/* testbench/tb_pmic_safety_sync.sv */
`timescale 1ns/1ps
`include "pmic_safety_regs.vh"
module tb_pmic_safety_sync;
  // ====================================================
  // signals
  reg CLOCK = 1'h0;
  reg RST_B = 1'h0;
  reg [3:0] AWADDR = 4'h0;
  reg [3:0] ARADDR = 4'h0;
  reg [3:0] WSTRB = 4'h1;
  reg [31:0] WDATA = 32'h0;
  reg AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
  reg FUSES_LOADED = 1'h1, FUSE_REG_HW_CONTROL_DEFAULT = 1'h1, FUSE_ACTIVE_SAFE_MODE = 1'h0;
  reg FUSE_FAIL_SYNC_ENABLE = 1'h1, FUSE_SECURE_ENABLE = 1'h1, REG_HW_ENABLE_PIN = 1'h0;
  reg STANDBY_STATE = 1'h0, REGULATOR_FAULT_PRESENT = 1'h0, SELF_TEST_FLAG = 1'h0;
  reg PROCESSOR_RESET_N = 1'h1, SUPPLY_UNDERVOLTAGE_DETECT = 1'h0, POWER_ON_REQUEST = 1'h1;
  reg OUTPUTS_OFF = 1'h1, CONFIG_MODE_STRAP = 1'h0, HARD_WATCHDOG_EVENT = 1'h0, hold = 1'h0;
  reg [7:0] ev = 8'h00;
  reg [31:0] d;
  wire SOFT_FAULT = ev[0], EXT_WATCHDOG_EVENT = ev[1], INT_WATCHDOG_EVENT = ev[2];
  wire FAULT_TIMER_EXPIRED = ev[3], FAULT_COUNT_MAX = ev[4], WATCHDOG_COUNT_MAX = ev[5];
  wire POWER_UP_FAILURE = ev[6], THERMAL_SHUTDOWN = ev[7];
  wire AWREADY, WREADY, BVALID, ARREADY, RVALID, FAIL_SYNC_LINE_IN;
  wire [1:0] BRESP, RRESP;
  wire [31:0] RDATA;
  wire AUX_LINEAR_REGULATOR_EN, SAFETY_OUT_N_O, SAFETY_OUT_N_OE, FAIL_SYNC_LINE_N_O;
  wire FAIL_SYNC_LINE_N_OE, POWER_DOWN_START, POWER_UP_GO, RELOAD_FUSES;
  wire CONFIG_PROGRAMMING_MODE, WATCHDOG_DISABLE, SECURE_CRC_DISABLE;
  wire [6:0] BUS_ADDRESS_OVERRIDE;
  integer n_fail = 0, samples_checked = 0, n_pd = 0, n_pu = 0, n_rl = 0;
  integer gap = 0, run = 0, cyc = 0;
  pmic_safety_sync dut (.*);
  peer_controller peer (.CLOCK(CLOCK), .hold_low(hold), .dut_oe(FAIL_SYNC_LINE_N_OE),
    .line(FAIL_SYNC_LINE_IN));
  always #12.5 CLOCK = !CLOCK;
  // ====================================================
  // event counters, fuse reload and hang guard
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    run <= FAIL_SYNC_LINE_N_OE ? run + 1 : 0;
    FUSES_LOADED <= !RELOAD_FUSES;
    if (POWER_DOWN_START) begin
      n_pd <= n_pd + 1;
      gap <= run;
    end
    if (POWER_UP_GO) n_pu <= n_pu + 1;
    if (RELOAD_FUSES) n_rl <= n_rl + 1;
    if (cyc == 80000) begin
      n_fail = n_fail + 1;
      report_and_stop;
    end
  end
  // ====================================================
  // bus tasks and comparison
  task axw(input [3:0] a, input [7:0] v);
    begin
      AWADDR <= a;
      WDATA <= {24'h000000, v};
      AWVALID <= 1'h1;
      WVALID <= 1'h1;
      BREADY <= 1'h1;
      do begin
        @(posedge CLOCK);
        if (AWREADY) AWVALID <= 1'h0;
        if (WREADY) WVALID <= 1'h0;
      end while (AWVALID || WVALID);
      while (!BVALID) @(posedge CLOCK);
      BREADY <= 1'h0;
      @(posedge CLOCK);
    end
  endtask
  task axr(input [3:0] a, output [31:0] v);
    begin
      ARADDR <= a;
      ARVALID <= 1'h1;
      RREADY <= 1'h1;
      do @(posedge CLOCK); while (!ARREADY);
      ARVALID <= 1'h0;
      while (!RVALID) @(posedge CLOCK);
      v = RDATA;
      RREADY <= 1'h0;
      @(posedge CLOCK);
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // state field 2 is the on state
  task wait_on;
    begin
      d = 32'h0;
      while (d[7:5] !== 3'h2) axr(`A_STATUS, d);
    end
  endtask
  // ====================================================
  // scenarios
  task scn_regulator;
    integer i;
    begin
      wait_on;
      for (i = 0; i < 16; i = i + 1) begin
        REG_HW_ENABLE_PIN <= i[2];
        STANDBY_STATE <= i[3];
        // the unused mode bit is set opposite, so a wrong bit choice shows
        axw(`A_CTRL, {5'h00, i[3] ? {i[1], !i[1]} : {!i[1], i[1]}, i[0]});
        axr(`A_STATUS, d);
        chk(d[`S_PIN], i[2]);
        chk(AUX_LINEAR_REGULATOR_EN, i[1] & (i[2] | !i[0]));
      end
      STANDBY_STATE <= 1'h0;
    end
  endtask
  task scn_faults;
    integer j, s, b, f, p;
    begin
      for (j = 0; j < 8; j = j + 1) begin
        for (s = 0; s < 2; s = s + 1) begin
          b = (j < 3) ? `C_SOFT + j : `C_HARD;
          f = (j < 3) ? `F_SOFT + j : `F_HARD;
          wait_on;
          axw(`A_CTRL, s[0] ? 8'h01 << b : 8'h00);
          p = n_pd;
          ev[j] <= 1'h1;
          @(posedge CLOCK);
          ev[j] <= 1'h0;
          axr(`A_FLAGS, d);
          chk(d[`NFLAGS-1:0], s[0] << f);
          chk(SAFETY_OUT_N_OE, s[0]);
          SUPPLY_UNDERVOLTAGE_DETECT <= 1'h1;
          repeat (3) @(posedge CLOCK);
          chk(SAFETY_OUT_N_OE, 0);
          SUPPLY_UNDERVOLTAGE_DETECT <= 1'h0;
          axw(`A_FLAGS, 8'h1f);
          axr(`A_FLAGS, d);
          chk(d[`NFLAGS-1:0] | SAFETY_OUT_N_OE, 0);
          if (j > 2) begin
            while (n_pd == p) @(posedge CLOCK);
            chk(gap >= 799 && gap <= 801, 1);
          end
        end
      end
    end
  endtask
  task scn_secure;
    reg [31:0] c;
    integer k;
    begin
      wait_on;
      axw(`A_CTRL, 8'h88);
      ev[0] <= 1'h1;
      @(posedge CLOCK);
      ev[0] <= 1'h0;
      for (k = 0; k < 2; k = k + 1) begin
        axw(`A_FLAGS, 8'h01);
        axr(`A_CODE, c);
        axw(`A_CODE, k ? c[7:0] : ~c[7:0]);
        axr(`A_FLAGS, d);
        chk(d[`F_SOFT], !k);
      end
    end
  endtask
  task scn_config;
    begin
      CONFIG_MODE_STRAP <= 1'h1;
      repeat (4) @(posedge CLOCK);
      axr(`A_STATUS, d);
      // system is on here, so crc and secure write stay enabled
      chk({d[`S_CFG], CONFIG_PROGRAMMING_MODE, WATCHDOG_DISABLE, SECURE_CRC_DISABLE}, 4'he);
      chk(BUS_ADDRESS_OVERRIDE, 7'h08);
      CONFIG_MODE_STRAP <= 1'h0;
      repeat (4) @(posedge CLOCK);
      chk({CONFIG_PROGRAMMING_MODE, BUS_ADDRESS_OVERRIDE}, 8'h00);
    end
  endtask
  task scn_debounce;
    integer p, q;
    begin
      wait_on;
      p = n_pd;
      q = n_pu;
      hold <= 1'h1;
      repeat (400) @(posedge CLOCK);
      hold <= 1'h0;
      repeat (2) @(posedge CLOCK);
      hold <= 1'h1;
      repeat (500) @(posedge CLOCK);
      chk(n_pd, p);
      repeat (3000) @(posedge CLOCK);
      chk(n_pd, p + 1);
      chk({n_pu == q, FAIL_SYNC_LINE_N_OE}, 2'h2);
      hold <= 1'h0;
      wait_on;
    end
  endtask
  task scn_hardwd;
    integer p, r, k;
    begin
      wait_on;
      FUSE_REG_HW_CONTROL_DEFAULT <= 1'h0;
      OUTPUTS_OFF <= 1'h0;
      p = n_pd;
      r = n_rl;
      HARD_WATCHDOG_EVENT <= 1'h1;
      @(posedge CLOCK);
      HARD_WATCHDOG_EVENT <= 1'h0;
      while (n_pd == p) @(posedge CLOCK);
      chk(gap >= 799 && gap <= 801, 1);
      repeat (20) @(posedge CLOCK);
      OUTPUTS_OFF <= 1'h1;
      k = 0;
      while (FAIL_SYNC_LINE_N_OE) begin
        @(posedge CLOCK);
        k = k + 1;
      end
      chk(k >= 1199 && k <= 1204, 1);
      wait_on;
      axr(`A_CTRL, d);
      chk({n_rl == r + 1, d[`C_HWSEL]}, 2'h2);
    end
  endtask
  // active mode is only taken at fuse capture, so a second reset applies it
  task scn_active;
    begin
      FUSE_ACTIVE_SAFE_MODE <= 1'h1;
      SELF_TEST_FLAG <= 1'h1;
      RST_B <= 1'h0;
      repeat (2) @(posedge CLOCK);
      RST_B <= 1'h1;
      repeat (4) @(posedge CLOCK);
      axr(`A_FLAGS, d);
      chk({SAFETY_OUT_N_OE, d[`F_SAFE]}, 2'h3);
      SELF_TEST_FLAG <= 1'h0;
      axw(`A_FLAGS, 8'h1f);
      axr(`A_FLAGS, d);
      chk({SAFETY_OUT_N_OE, d[`F_SAFE]}, 2'h0);
    end
  endtask
  task report_and_stop;
    begin
      $display("compares %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (8) @(posedge CLOCK);
    RST_B <= 1'h1;
    @(posedge CLOCK);
    axr(`A_CTRL, d);
    chk(d, 32'h1);
    scn_regulator;
    scn_faults;
    scn_secure;
    scn_config;
    scn_debounce;
    scn_hardwd;
    scn_active;
    report_and_stop;
  end
endmodule // tb_pmic_safety_sync
bind pmic_safety_sync pmic_safety_props props (.*);
